// File: common/fsp_pkg.sv
package fsp_pkg;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int DATA_W = 8;
  localparam int REG_AW = 3;
  localparam int LOCK_W = 2;
  localparam int CNT_W = 20;
  // halting section is the top 2K words, so every boot size fits in it
  localparam logic [ADDR_W-1:0] HALT_START = 13'h1800;
  localparam logic [ADDR_W-1:0] BOOT_START_256 = 13'h1F00;
  localparam logic [ADDR_W-1:0] BOOT_START_512 = 13'h1E00;
  localparam logic [ADDR_W-1:0] BOOT_START_1K = 13'h1C00;
  localparam logic [ADDR_W-1:0] BOOT_START_2K = 13'h1800;
  localparam logic [REG_AW-1:0] OFS_CTRL = 3'h0;
  localparam logic [REG_AW-1:0] OFS_LOCK = 3'h1;
  localparam logic [REG_AW-1:0] OFS_STAT = 3'h2;
  localparam logic [REG_AW-1:0] OFS_MASK = 3'h3;
  localparam int CTRL_EN = 0;
  localparam int CTRL_ERASE = 1;
  localparam int CTRL_WRITE = 2;
  localparam int CTRL_LOCKSET = 3;
  localparam int CTRL_BUSYCLR = 4;
  localparam int CTRL_BUSY = 6;
  localparam int CTRL_CMD_W = 5;
  localparam int LOCK_APP = 0;
  localparam int LOCK_BOOT = 1;
  localparam int STAT_DONE = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_W = 2;
  localparam logic [CTRL_CMD_W-1:0] CTRL_RST = 5'h00;
  localparam logic [LOCK_W-1:0] LOCK_RST = 2'h0;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [1:0] FUSE_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
  localparam int unsigned OP_TIME_NS = 4000000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned OP_CYCLES_DFLT = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_RUN = 2'b01,
    FSP_HALT = 2'b10
  } fsp_state_t;

  function automatic logic [ADDR_W-1:0] boot_start(input logic [1:0] fuses);
    logic [ADDR_W-1:0] s;
    case (fuses)
      2'h3: s = BOOT_START_256;
      2'h2: s = BOOT_START_512;
      2'h1: s = BOOT_START_1K;
      default: s = BOOT_START_2K;
    endcase
    return s;
  endfunction

  function automatic logic in_boot(input logic [ADDR_W-1:0] a, input logic [1:0] fuses);
    return a >= boot_start(fuses);
  endfunction

  function automatic logic in_halt(input logic [ADDR_W-1:0] a);
    return a >= HALT_START;
  endfunction
endpackage

// File: dv/fsp_core_model.sv
`timescale 1ns/100ps
module fsp_core_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // request from the bench
  input wire logic go,
  input wire logic [fsp_pkg::ADDR_W-1:0] pc,
  input wire logic [fsp_pkg::ADDR_W-1:0] addr,
  input wire logic [fsp_pkg::LOCK_W-1:0] lock_val,
  input wire logic core_stall,
  // store-program instruction
  output logic prog_valid,
  output logic [fsp_pkg::ADDR_W-1:0] prog_pc,
  output logic [fsp_pkg::ADDR_W-1:0] prog_addr,
  output logic [fsp_pkg::LOCK_W-1:0] prog_lock_val
);
  import fsp_pkg::*;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prog_valid <= 1'b0;
      prog_pc <= 13'h0AAA;
      prog_addr <= 13'h1555;
      prog_lock_val <= 2'h2;
    end
    else if (go && !core_stall)
    begin
      prog_valid <= 1'b1;
      prog_pc <= pc;
      prog_addr <= addr;
      prog_lock_val <= lock_val;
    end
    else
    begin
      // operands mean nothing outside the pulse, so keep them moving
      prog_valid <= 1'b0;
      prog_pc <= ~prog_pc;
      prog_addr <= ~prog_addr;
      prog_lock_val <= ~prog_lock_val;
    end
  end
endmodule

// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import fsp_pkg::*;
  logic core_clk, rst, ce, reg_wr, reg_rd, irq, prog_valid, fetch_blocked, core_stall;
  logic flash_erase_req, flash_write_req, chip_erase, go;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, flash_page, exp_wr, exp_er;
  logic [12:0] prog_pc, prog_addr, fetch_addr, op_pc, op_addr;
  logic [1:0] prog_lock_val, op_lk, boot_size_fuses;
  logic [7:0] n_wr = 8'h00;
  logic [7:0] n_er = 8'h00;
  logic [12:0] bstart [4] = '{13'h1800, 13'h1C00, 13'h1E00, 13'h1F00};
  int err_total, samples_checked;

  fsp_flash_ctrl #(.OP_CYCLES(40)) dut (.core_clk(core_clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .prog_valid(prog_valid), .prog_pc(prog_pc),
    .prog_addr(prog_addr), .prog_lock_val(prog_lock_val), .fetch_addr(fetch_addr),
    .fetch_blocked(fetch_blocked), .core_stall(core_stall),
    .flash_erase_req(flash_erase_req), .flash_write_req(flash_write_req),
    .flash_page(flash_page), .boot_size_fuses(boot_size_fuses), .chip_erase(chip_erase));

  fsp_core_model core (.core_clk(core_clk), .rst(rst), .go(go), .pc(op_pc), .addr(op_addr),
    .lock_val(op_lk), .core_stall(core_stall), .prog_valid(prog_valid), .prog_pc(prog_pc),
    .prog_addr(prog_addr), .prog_lock_val(prog_lock_val));

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (flash_write_req)
      n_wr <= n_wr + 8'h01;
    if (flash_erase_req)
      n_er <= n_er + 8'h01;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic fetch(input logic [12:0] a, input logic exp);
    @(posedge core_clk);
    fetch_addr <= a;
    #1;
    chk({7'h00, fetch_blocked}, {7'h00, exp});
  endtask

  task automatic prog(input logic [7:0] ctl, input logic [12:0] p, input logic [12:0] a,
    input logic [1:0] lk);
    wr(OFS_CTRL, ctl);
    @(posedge core_clk);
    go <= 1'b1;
    op_pc <= p;
    op_addr <= a;
    op_lk <= lk;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (irq !== 1'b1)
    begin
      err_total++;
      results();
    end
  endtask

  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    op_pc = 13'h0000;
    op_addr = 13'h0000;
    op_lk = 2'h0;
    fetch_addr = 13'h1900;
    chip_erase = 1'b0;
    boot_size_fuses = 2'h0;
    exp_wr = 8'h00;
    exp_er = 8'h00;
    err_total = 0;
    samples_checked = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(i[2:0], 8'h00);
    wr(OFS_MASK, 8'h01);
    for (int f = 0; f < 4; f++)
    begin
      boot_size_fuses <= f[1:0];
      repeat (4) @(posedge core_clk);
      prog(8'h05, bstart[f] - 13'h0001, 13'h0045, 2'h0);
      rd(OFS_STAT, 8'h02);
      prog(8'h05, bstart[f], 13'h0045, 2'h0);
      exp_wr = exp_wr + 8'h01;
      chk(n_wr, exp_wr);
      // a second op while one runs is refused
      prog(8'h05, bstart[f], 13'h0060, 2'h0);
      chk(flash_page, 8'h02);
      rd(OFS_CTRL, 8'h40);
      fetch(13'h0100, 1'b1);
      fetch(13'h1900, 1'b0);
      chk({7'h00, core_stall}, 8'h00);
      wait_irq();
      rd(OFS_STAT, 8'h03);
      chk(n_wr, exp_wr);
      rd(OFS_CTRL, 8'h40);
      fetch(13'h0100, 1'b1);
      prog(8'h11, bstart[f], 13'h0000, 2'h0);
      rd(OFS_CTRL, 8'h00);
      fetch(13'h0100, 1'b0);
      // bench leaves the fetch address in the halting section until the next fetch call
      fetch(13'h1900, 1'b0);
    end
    prog(8'h07, 13'h1F00, 13'h1F20, 2'h0);
    exp_er = exp_er + 8'h01;
    chk(n_er, exp_er);
    chk(n_wr, exp_wr);
    chk(flash_page, 8'hF9);
    chk({7'h00, core_stall}, 8'h01);
    fetch(13'h1900, 1'b1);
    fetch(13'h0100, 1'b1);
    wait_irq();
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h00, core_stall}, 8'h00);
    rd(OFS_STAT, 8'h01);
    // enable bit clear: a boot section instruction is still refused
    prog(8'h04, 13'h1F00, 13'h0045, 2'h0);
    chk(n_wr, exp_wr);
    rd(OFS_STAT, 8'h02);
    prog(8'h09, 13'h1F00, 13'h0000, 2'h1);
    rd(OFS_LOCK, 8'h01);
    wr(OFS_LOCK, 8'h00);
    rd(OFS_LOCK, 8'h01);
    prog(8'h05, 13'h1F00, 13'h0045, 2'h0);
    rd(OFS_STAT, 8'h02);
    prog(8'h05, 13'h1F00, 13'h1F20, 2'h0);
    exp_wr = exp_wr + 8'h01;
    chk(n_wr, exp_wr);
    wait_irq();
    rd(OFS_STAT, 8'h01);
    prog(8'h09, 13'h1F00, 13'h0000, 2'h2);
    rd(OFS_LOCK, 8'h03);
    prog(8'h05, 13'h1F00, 13'h1F20, 2'h0);
    chk(n_wr, exp_wr);
    chk({7'h00, irq}, 8'h00);
    wr(OFS_MASK, 8'h02);
    #1;
    chk({7'h00, irq}, 8'h01);
    rd(OFS_STAT, 8'h02);
    chk({7'h00, irq}, 8'h00);
    @(posedge core_clk);
    chip_erase <= 1'b1;
    repeat (4) @(posedge core_clk);
    chip_erase <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(OFS_LOCK, 8'h00);
    results();
  end
endmodule

// File: hdl/fsp_flash_ctrl.sv
`timescale 1ns/100ps
// Function
// R01: programming starts only for a store-program fetched from the boot loader section
// R02: store-program executed from the application section is ignored
// R03: boot loader store-program may target any flash address, boot section included
// R04: boot size fuses set the application/boot loader boundary
// R05: application section protection follows the application lock bits only
// R06: boot loader section protection follows the boot loader lock bits only
// R07: readable-section operations keep the core running, halting section readable
// R08: halting-section operations stall the core, no section readable
// R09: readable-section code is never returned during any operation
// R10: busy flag reads one while the readable section is blocked; code sets it for readable-section operations only, not halting ones
// R11: busy flag stays set after completion until software clears it
// R12: the whole boot loader section lies inside the halting section
// R13: software should mask interrupts while programming the readable section
// R14: programming works on whole pages; normal reads ignore page layout
// R15: lock bits set by software or programmer, cleared only by chip erase; code also clears them on rst
// R16: stall releases by itself when a halting-section operation finishes
module fsp_flash_ctrl #(
  parameter int unsigned OP_CYCLES = fsp_pkg::OP_CYCLES_DFLT
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [fsp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [fsp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fsp_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  // store-program instruction from the core
  input wire logic prog_valid,
  input wire logic [fsp_pkg::ADDR_W-1:0] prog_pc,
  input wire logic [fsp_pkg::ADDR_W-1:0] prog_addr,
  input wire logic [fsp_pkg::LOCK_W-1:0] prog_lock_val,
  // core fetch path
  input wire logic [fsp_pkg::ADDR_W-1:0] fetch_addr,
  output logic fetch_blocked,
  output logic core_stall,
  // flash array
  output logic flash_erase_req,
  output logic flash_write_req,
  output logic [fsp_pkg::ADDR_W-fsp_pkg::PAGE_W-1:0] flash_page,
  // pins
  input wire logic [1:0] boot_size_fuses,
  input wire logic chip_erase
);
  import fsp_pkg::*;

  logic [1:0] fuse_s1_q;
  logic [1:0] fuse_q;
  logic erase_s1_q;
  logic erase_q;
  logic [CTRL_CMD_W-1:0] ctrl_q;
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic busy_q;
  logic stall_q;
  logic erase_req_q;
  logic write_req_q;
  logic [ADDR_W-PAGE_W-1:0] page_q;
  fsp_state_t state_q;
  fsp_state_t state_d;
  logic [LOCK_W-1:0] lock_bits;
  logic op_done;
  logic pc_boot;
  logic tgt_boot;
  logic tgt_halt;
  logic tgt_locked;
  logic cmd_prog;
  logic prog_ok;
  logic go;
  logic refuse;
  logic lock_set;
  logic busy_clr;
  logic stat_rd;
  logic [STAT_W-1:0] events;

  // fuses and chip erase come from outside the clock domain
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fuse_s1_q <= FUSE_RST;
      fuse_q <= FUSE_RST;
      erase_s1_q <= 1'b0;
      erase_q <= 1'b0;
    end
    else if (ce)
    begin
      fuse_s1_q <= boot_size_fuses;
      fuse_q <= fuse_s1_q;
      erase_s1_q <= chip_erase;
      erase_q <= erase_s1_q;
    end
  end

  assign pc_boot = in_boot(prog_pc, fuse_q); // R04
  assign tgt_boot = in_boot(prog_addr, fuse_q); // R04
  assign tgt_halt = in_halt(prog_addr); // R08 R12
  // each section consults only its own lock bit
  assign tgt_locked = tgt_boot ? lock_bits[LOCK_BOOT] : lock_bits[LOCK_APP]; // R05 R06
  assign cmd_prog = ctrl_q[CTRL_ERASE] | ctrl_q[CTRL_WRITE];
  assign prog_ok = prog_valid & pc_boot & ctrl_q[CTRL_EN]; // R01 R02
  // no address range check: boot code reaches the whole array
  assign go = prog_ok & cmd_prog & ~tgt_locked & (state_q == FSP_IDLE); // R03
  assign lock_set = prog_ok & ~cmd_prog & ctrl_q[CTRL_LOCKSET];
  assign busy_clr = prog_ok & ~cmd_prog & ctrl_q[CTRL_BUSYCLR] & (state_q == FSP_IDLE);
  assign refuse = prog_valid & ~(go | (prog_ok & ~cmd_prog)); // R02
  assign stat_rd = reg_rd & (reg_addr == OFS_STAT);
  assign events = {refuse, op_done};

  fsp_op_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .start(go),
    .done(op_done)
  );

  fsp_lock_bits u_lock (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .set_en(lock_set),
    .set_val(prog_lock_val),
    .chip_erase(erase_q),
    .lock_bits(lock_bits)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FSP_IDLE:
      begin
        if (go)
          state_d = tgt_halt ? FSP_HALT : FSP_RUN; // R07 R08
      end
      FSP_RUN, FSP_HALT:
      begin
        if (op_done)
          state_d = FSP_IDLE; // R16
      end
      default: state_d = FSP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_q <= FSP_IDLE;
    else if (ce)
      state_q <= state_d;
  end

  // stall covers the whole halting operation and drops with its end
  always_ff @(posedge core_clk)
  begin
    if (rst)
      stall_q <= 1'b0;
    else if (ce)
    begin
      if (go && tgt_halt)
        stall_q <= 1'b1; // R08
      else if (op_done)
        stall_q <= 1'b0; // R16
    end
  end

  // busy is sticky past completion so stale code is never run
  always_ff @(posedge core_clk)
  begin
    if (rst)
      busy_q <= 1'b0;
    else if (ce)
      busy_q <= (go & ~tgt_halt) | (busy_q & ~busy_clr); // R10 R11
  end

  // erase and write always act on a whole page
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      erase_req_q <= 1'b0;
      write_req_q <= 1'b0;
      page_q <= '0;
    end
    else if (ce)
    begin
      erase_req_q <= go & ctrl_q[CTRL_ERASE];
      write_req_q <= go & ~ctrl_q[CTRL_ERASE];
      if (go)
        page_q <= prog_addr[ADDR_W-1:PAGE_W]; // R14
    end
  end

  // command bits are one-shot: consumed by the next enabled boot-section instruction, refused or not
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_q <= CTRL_RST;
    else if (ce)
    begin
      if (reg_wr && reg_addr == OFS_CTRL)
        ctrl_q <= reg_wdata[CTRL_CMD_W-1:0];
      else if (prog_ok)
        ctrl_q <= CTRL_RST;
    end
  end

  // events win over the clearing read
  always_ff @(posedge core_clk)
  begin
    if (rst)
      stat_q <= STAT_RST;
    else if (ce)
      stat_q <= (stat_rd ? STAT_RST : stat_q) | events;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      mask_q <= STAT_RST;
    else if (ce && reg_wr && reg_addr == OFS_MASK)
      mask_q <= reg_wdata[STAT_W-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_q <= '0;
    else if (ce)
    begin
      rdata_q <= '0;
      if (reg_rd)
      begin
        case (reg_addr)
          OFS_CTRL: rdata_q <= {1'b0, busy_q, 1'b0, ctrl_q}; // R10
          OFS_LOCK: rdata_q <= {{(DATA_W-LOCK_W){1'b0}}, lock_bits};
          OFS_STAT: rdata_q <= {{(DATA_W-STAT_W){1'b0}}, stat_q};
          OFS_MASK: rdata_q <= {{(DATA_W-STAT_W){1'b0}}, mask_q};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = |(stat_q & mask_q);
  // page layout never enters the fetch check
  assign fetch_blocked = stall_q | (busy_q & ~in_halt(fetch_addr)); // R07 R09 R14
  assign core_stall = stall_q;
  assign flash_erase_req = erase_req_q;
  assign flash_write_req = write_req_q;
  assign flash_page = page_q;

  a_start_from_boot: assert property ( // R01
    @(posedge core_clk) disable iff (rst)
    $rose(flash_erase_req | flash_write_req) |-> $past(prog_valid && pc_boot))
    else $error("flash operation started without boot section fetch");

  a_app_ignored: assert property ( // R02
    @(posedge core_clk) disable iff (rst)
    (ce && prog_valid && !pc_boot) |=> !(flash_erase_req || flash_write_req))
    else $error("application section store-program started an operation");

  a_lock_guard: assert property ( // R05
    @(posedge core_clk) disable iff (rst)
    (ce && prog_valid && tgt_locked) |=> !(flash_erase_req || flash_write_req))
    else $error("operation started on a locked section");

  a_run_no_stall: assert property ( // R07
    @(posedge core_clk) disable iff (rst)
    (state_q == FSP_RUN) |-> !core_stall && (fetch_blocked == !in_halt(fetch_addr)))
    else $error("readable-section operation stalls core or blocks halting fetch");

  a_halt_stall: assert property ( // R08
    @(posedge core_clk) disable iff (rst)
    (ce && go && tgt_halt) |=> core_stall && fetch_blocked && state_q == FSP_HALT)
    else $error("halting-section operation did not stall the core");

  a_busy_during_run: assert property ( // R10
    @(posedge core_clk) disable iff (rst)
    (ce && go && !tgt_halt) |=> busy_q [*2])
    else $error("busy flag not set for readable-section operation");

  a_busy_sticky: assert property ( // R11
    @(posedge core_clk) disable iff (rst)
    (busy_q && state_q == FSP_IDLE && !(ce && busy_clr)) |=> busy_q)
    else $error("busy flag dropped without software clear");

  a_boot_in_halt: assert property ( // R12
    @(posedge core_clk) disable iff (rst)
    (prog_valid && pc_boot) |-> in_halt(prog_pc))
    else $error("boot loader section extends below halting section");

  a_page_capture: assert property ( // R14
    @(posedge core_clk) disable iff (rst)
    (ce && go) |=> flash_page == $past(prog_addr[ADDR_W-1:PAGE_W]))
    else $error("page index not taken from target address");

  a_stall_release: assert property ( // R16
    @(posedge core_clk) disable iff (rst)
    (ce && op_done && state_q == FSP_HALT) |=> !core_stall && state_q == FSP_IDLE)
    else $error("stall not released at operation end");

  c_run_op: cover property (
    @(posedge core_clk) disable iff (rst)
    (ce && go && !tgt_halt) ##[1:1000] (ce && busy_clr));

  c_halt_op: cover property (
    @(posedge core_clk) disable iff (rst)
    $rose(core_stall) ##[1:1000] $fell(core_stall));

  c_refused: cover property (
    @(posedge core_clk) disable iff (rst)
    ce && refuse && !pc_boot);
endmodule

// File: hdl/fsp_lock_bits.sv
`timescale 1ns/100ps
module fsp_lock_bits (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // update
  input wire logic set_en,
  input wire logic [fsp_pkg::LOCK_W-1:0] set_val,
  input wire logic chip_erase,
  // state
  output logic [fsp_pkg::LOCK_W-1:0] lock_bits
);
  import fsp_pkg::*;
  logic [LOCK_W-1:0] lock_q;

  // software may only add protection; only chip erase or rst removes it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      lock_q <= LOCK_RST;
    else if (ce)
    begin
      if (chip_erase)
        lock_q <= LOCK_RST; // R15
      else if (set_en)
        lock_q <= lock_q | set_val; // R15
    end
  end

  assign lock_bits = lock_q;
endmodule

// File: hdl/fsp_op_timer.sv
`timescale 1ns/100ps
module fsp_op_timer #(
  parameter int unsigned CYCLES = fsp_pkg::OP_CYCLES_DFLT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic start,
  output logic done
);
  import fsp_pkg::*;
  logic [CNT_W-1:0] cnt_q;
  logic done_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end
    else if (ce)
    begin
      done_q <= (cnt_q == CNT_ONE) && !start;
      if (start)
        cnt_q <= CNT_W'(CYCLES);
      else if (cnt_q != '0)
        cnt_q <= cnt_q - CNT_ONE;
    end
  end

  assign done = done_q;
endmodule
